// ===== rtl/rbrs_pkg.sv
// Constants, encodings and timing counts for the burst read sequencer
package rbrs_pkg;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          CARRIER_DIV   = 128;
  localparam int          DIV_W         = $clog2(CARRIER_DIV);
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BURST_ON_MS   = 80;
  localparam int          BURST_OFF_MS  = 30;
  localparam int          FLASH_MS      = 50;
  localparam int          BAUD_RATE     = 9600;
  localparam int          BIT_NS        = 1000000000 / BAUD_RATE;
  localparam int          BAUD_CYCLES   = BIT_NS / CLK_PERIOD_NS;
  localparam int          ID_W          = 40;
  localparam int          ID_BYTES      = 5;
  localparam int          HDX_BITS      = 48;
  localparam int          FDX_BITS      = 49;
  localparam int          BITCNT_W      = 6;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          LOG_DEPTH     = 16;
  localparam logic [4:0]  PIN_RST       = 5'h10;
  localparam logic [7:0]  HDX_HDR       = 8'h7E;
  localparam logic [7:0]  FDX_HDR       = 8'h81;
  localparam logic [7:0]  NVM_CFG_ADDR  = 8'h00;
  localparam logic [7:0]  NVM_LOG_BASE  = 8'h01;
  localparam logic [7:0]  CFG_SIG       = 8'hA5;
  localparam logic [7:0]  CFG_RESET     = 8'h01;
  localparam int          CFG_TERM_BIT  = 0;
  // Arbitrary value, no meaning beyond this design
  localparam logic [7:0]  VERSION       = 8'h10;
  localparam logic [7:0]  ERR_UNKNOWN   = 8'h01;
  localparam logic [7:0]  CH_V          = 8'h56;
  localparam logic [7:0]  CH_C          = 8'h43;
  localparam logic [7:0]  CH_S          = 8'h53;
  localparam logic [7:0]  CH_M          = 8'h4D;
  localparam logic [7:0]  CH_L          = 8'h4C;
  localparam logic [7:0]  CH_Q          = 8'h3F;
  localparam logic [7:0]  CH_E          = 8'h45;
  localparam logic [7:0]  CH_K          = 8'h4B;
  localparam logic [7:0]  CH_CR         = 8'h0D;
  localparam logic [7:0]  CH_LF         = 8'h0A;
  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_ON, ST_OFF, ST_SEND, ST_STORE, ST_ARG, ST_LOG} rbrs_state_t;
endpackage

// ===== rtl/rbrs_fifo.sv
// Byte FIFO between the record formatter and the serial transmitter
`timescale 1ns/1ps
module rbrs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         do_wr;
  logic         do_rd;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ===== rtl/rbrs_uart.sv
// Serial transmitter and receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module rbrs_uart #(
  parameter int BAUD_CYCLES = rbrs_pkg::BAUD_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            txd,
  input  wire logic       rxd,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  localparam int CW = $clog2(BAUD_CYCLES);
  logic [CW-1:0] tcnt, next_tcnt, rcnt, next_rcnt;
  logic [3:0]    tbits, next_tbits, rbits, next_rbits;
  logic [8:0]    tsh, next_tsh;
  logic [7:0]    rsh, next_rsh, next_rx_data;
  logic          next_txd, next_rx_valid;
  logic          rx_s1, rx_s2;

  assign tx_ready = (tbits == 4'h0);

  always_comb begin
    next_tcnt  = tcnt;
    next_tbits = tbits;
    next_tsh   = tsh;
    next_txd   = txd;
    if (tbits == 4'h0) begin
      if (tx_valid) begin
        next_tsh   = {1'b1, tx_data};
        next_tbits = 4'hA;
        next_tcnt  = '0;
        next_txd   = 1'b0;
      end
    end else if (tcnt == CW'(BAUD_CYCLES - 1)) begin
      next_tcnt  = '0;
      next_tbits = tbits - 4'h1;
      if (tbits != 4'h1) begin
        next_txd = tsh[0];
        next_tsh = {1'b1, tsh[8:1]};
      end
    end else begin
      next_tcnt = tcnt + 1'b1;
    end
  end

  // Receive samples mid-bit; a bad stop bit drops the byte
  always_comb begin
    next_rcnt     = rcnt;
    next_rbits    = rbits;
    next_rsh      = rsh;
    next_rx_valid = 1'b0;
    next_rx_data  = rx_data;
    if (rbits == 4'h0) begin
      if (!rx_s2) begin
        next_rbits = 4'hA;
        next_rcnt  = CW'(BAUD_CYCLES / 2);
      end
    end else if (rcnt == CW'(BAUD_CYCLES - 1)) begin
      next_rcnt  = '0;
      next_rbits = rbits - 4'h1;
      if (rbits == 4'hA && rx_s2) begin
        next_rbits = 4'h0;
      end else if (rbits == 4'h1) begin
        next_rx_valid = rx_s2;
        next_rx_data  = rsh;
      end else if (rbits != 4'hA) begin
        next_rsh = {rx_s2, rsh[7:1]};
      end
    end else begin
      next_rcnt = rcnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tcnt     <= '0;
      tbits    <= 4'h0;
      tsh      <= 9'h1FF;
      txd      <= 1'b1;
      rcnt     <= '0;
      rbits    <= 4'h0;
      rsh      <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
    end else begin
      tcnt     <= next_tcnt;
      tbits    <= next_tbits;
      tsh      <= next_tsh;
      txd      <= next_txd;
      rcnt     <= next_rcnt;
      rbits    <= next_rbits;
      rsh      <= next_rsh;
      rx_valid <= next_rx_valid;
      rx_data  <= next_rx_data;
      rx_s1    <= rxd;
      rx_s2    <= rx_s1;
    end
  end
endmodule

// ===== rtl/rbrs_top.sv
// Burst read sequencer: carrier bursts, tag decode, indicators, serial records and commands
// Notes on behaviour
// R01 - Carrier is system clock divided by 128
// R02 - Carrier control holds the divider in reset
// R03 - Bursts repeat 80 ms on, 30 ms off
// R04 - Half-duplex replies sought only while carrier off
// R05 - Full-duplex replies sought only while carrier on
// R06 - Each type: data plus sync, own decoder
// R07 - Red indicator follows burst on/off timing
// R08 - Valid read pulses green and beeper
// R09 - Valid read stops bursts, red goes off
// R10 - New cycle needs button release then press
// R11 - Load and check stored configuration at start
// R12 - Bursts wait for a button press
// R13 - Send each decoded record on serial output
// R14 - Store each decoded code in memory
// R15 - Commands taken only when idle and quiet
// R16 - Version, config query, config set, list, mode
// R17 - Unknown command answers with error code
// R18 - Burst timing counted from the system clock
`timescale 1ns/1ps
module rbrs_top #(
  parameter int MS_CYCLES   = rbrs_pkg::MS_CYCLES,
  parameter int BAUD_CYCLES = rbrs_pkg::BAUD_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     read_btn_n,
  input  wire logic                     hdx_data,
  input  wire logic                     hdx_sync,
  input  wire logic                     fdx_data,
  input  wire logic                     fdx_sync,
  input  wire logic                     uart_rxd,
  output logic                          uart_txd,
  output logic                          carrier_out,
  output logic                          red_led,
  output logic                          green_led,
  output logic                          beeper,
  output logic                          nvm_req,
  output logic                          nvm_we,
  output logic [7:0]                    nvm_addr,
  output logic [rbrs_pkg::ID_W-1:0]     nvm_wdata,
  input  wire logic [rbrs_pkg::ID_W-1:0] nvm_rdata,
  input  wire logic                     nvm_ack
);
  localparam int MW = $clog2(MS_CYCLES);
  localparam int IW = rbrs_pkg::ID_W;
  localparam int BW = rbrs_pkg::BITCNT_W;

  rbrs_pkg::rbrs_state_t state, next_state;
  logic [4:0]   pin_s1, pin_s2, pin_s3;
  logic [MW-1:0] ms_div, next_ms_div;
  logic         ms_tick;
  logic [rbrs_pkg::DIV_W-1:0] div, next_div;
  logic         car_on, next_car_on, next_carrier, next_red, next_green;
  logic [6:0]   ms_cnt, next_ms_cnt;
  logic [7:0]   flash, next_flash, cfg, next_cfg, cmd, next_cmd;
  logic         mode, next_mode, store, next_store, term, next_term;
  logic [IW-1:0] rec, next_rec, next_nvm_wdata;
  logic [2:0]   len, next_len, idx, next_idx;
  logic [3:0]   log_ptr, next_log_ptr;
  logic         next_nvm_req, next_nvm_we;
  logic [7:0]   next_nvm_addr;
  logic [rbrs_pkg::HDX_BITS-1:0] hsr, next_hsr;
  logic [rbrs_pkg::FDX_BITS-1:0] fsr, next_fsr;
  logic [BW-1:0] hcnt, next_hcnt, fcnt, next_fcnt;
  logic         pressed, press, hclk_rise, fclk_rise, hdx_hit, fdx_hit, dec_valid;
  logic [IW-1:0] dec_id;
  logic         push, fifo_ready, fifo_valid, tx_ready, rx_valid, tx_quiet, last;
  logic [7:0]   push_data, fifo_data, rx_data;

  function automatic logic [7:0] byte_of(input logic [IW-1:0] r, input logic [2:0] i);
    logic [IW-1:0] s;
    s = r >> (8 * (rbrs_pkg::ID_BYTES - 1 - int'(i)));
    return s[7:0];
  endfunction

  function automatic logic [IW-1:0] msg(input logic [7:0] a, input logic [7:0] b);
    return {a, b, 24'h00_0000};
  endfunction

  // Pins cross into the clock domain through two flops; third copy for edges
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          pin_s1[g] <= rbrs_pkg::PIN_RST[g];
          pin_s2[g] <= rbrs_pkg::PIN_RST[g];
          pin_s3[g] <= rbrs_pkg::PIN_RST[g];
        end else begin
          pin_s1[g] <= g == 4 ? read_btn_n : g == 3 ? hdx_data : g == 2 ? hdx_sync : g == 1 ? fdx_data : fdx_sync;
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
        end
      end
    end
  endgenerate

  // R10 edge only
  assign pressed   = !pin_s2[4];
  assign press     = pressed && pin_s3[4];
  assign hclk_rise = pin_s2[2] && !pin_s3[2];
  assign fclk_rise = pin_s2[0] && !pin_s3[0];
  // R18 ms enable
  assign ms_tick   = (ms_div == MW'(MS_CYCLES - 1));
  assign tx_quiet  = !fifo_valid && tx_ready;

  // R06 separate decoders
  assign hdx_hit   = (hcnt == BW'(rbrs_pkg::HDX_BITS)) && (hsr[47:40] == rbrs_pkg::HDX_HDR);
  assign fdx_hit   = (fcnt == BW'(rbrs_pkg::FDX_BITS)) && (fsr[48:41] == rbrs_pkg::FDX_HDR) && ((^fsr[40:1]) == fsr[0]);
  assign dec_valid = ((state == rbrs_pkg::ST_OFF) && hdx_hit) || ((state == rbrs_pkg::ST_ON) && fdx_hit);
  assign dec_id    = (state == rbrs_pkg::ST_OFF) ? hsr[39:0] : fsr[40:1];
  assign last      = term ? (idx == len + 3'h1) : (idx == len - 3'h1);

  always_comb begin
    next_hsr  = hsr;
    next_hcnt = hcnt;
    next_fsr  = fsr;
    next_fcnt = fcnt;
    // R04 off window
    if (state != rbrs_pkg::ST_OFF) begin
      next_hcnt = '0;
    end else if (hclk_rise) begin
      next_hsr = {hsr[46:0], pin_s2[3]};
      if (hcnt != BW'(rbrs_pkg::HDX_BITS)) next_hcnt = hcnt + 1'b1;
    end
    // R05 on window
    if (state != rbrs_pkg::ST_ON) begin
      next_fcnt = '0;
    end else if (fclk_rise) begin
      next_fsr = {fsr[47:0], pin_s2[1]};
      if (fcnt != BW'(rbrs_pkg::FDX_BITS)) next_fcnt = fcnt + 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_ms_cnt = ms_cnt;
    next_rec = rec;
    next_len = len;
    next_idx = idx;
    next_term = term;
    next_cfg = cfg;
    next_mode = mode;
    next_cmd = cmd;
    next_store = store;
    next_log_ptr = log_ptr;
    next_flash = flash;
    next_nvm_req = nvm_req;
    next_nvm_we = nvm_we;
    next_nvm_addr = nvm_addr;
    next_nvm_wdata = nvm_wdata;
    push = 1'b0;
    push_data = 8'h00;
    next_ms_div = ms_tick ? '0 : ms_div + 1'b1;
    if (ms_tick && flash != 8'h00) next_flash = flash - 8'h01;
    case (state)
      // R11 load and check
      rbrs_pkg::ST_LOAD: begin
        next_nvm_req  = 1'b1;
        next_nvm_we   = 1'b0;
        next_nvm_addr = rbrs_pkg::NVM_CFG_ADDR;
        if (nvm_req && nvm_ack) begin
          next_nvm_req = 1'b0;
          if (nvm_rdata[15:8] == rbrs_pkg::CFG_SIG) next_cfg = nvm_rdata[7:0];
          next_state = rbrs_pkg::ST_IDLE;
        end
      end
      rbrs_pkg::ST_IDLE: begin
        next_idx = 3'h0;
        next_term = 1'b0;
        next_store = 1'b0;
        // R12 wait for press
        if (press && !mode) begin
          next_state  = rbrs_pkg::ST_ON;
          next_ms_cnt = 7'h00;
        // R15 only when quiet
        end else if (rx_valid && tx_quiet) begin
          next_cmd = rx_data;
          next_state = rbrs_pkg::ST_SEND;
          next_len = 3'h2;
          // R16 command set
          if (rx_data == rbrs_pkg::CH_V) begin
            next_rec = msg(rbrs_pkg::CH_V, rbrs_pkg::VERSION);
          end else if (rx_data == rbrs_pkg::CH_C) begin
            next_rec = msg(rbrs_pkg::CH_C, cfg);
          end else if (rx_data == rbrs_pkg::CH_Q) begin
            next_rec = {rbrs_pkg::CH_V, rbrs_pkg::CH_C, rbrs_pkg::CH_S, rbrs_pkg::CH_M, rbrs_pkg::CH_L};
            next_len = 3'h5;
          end else if (rx_data == rbrs_pkg::CH_S || rx_data == rbrs_pkg::CH_M) begin
            next_state = rbrs_pkg::ST_ARG;
          end else if (rx_data == rbrs_pkg::CH_L) begin
            next_state = rbrs_pkg::ST_LOG;
          end else begin
            // R17 error reply
            next_rec = msg(rbrs_pkg::CH_E, rbrs_pkg::ERR_UNKNOWN);
          end
        end
      end
      rbrs_pkg::ST_ON, rbrs_pkg::ST_OFF: begin
        if (dec_valid) begin
          // R09 stop on read
          next_state = rbrs_pkg::ST_SEND;
          next_rec = dec_id;
          next_len = 3'(rbrs_pkg::ID_BYTES);
          next_term = cfg[rbrs_pkg::CFG_TERM_BIT];
          next_store = 1'b1;
          // R08 green and beep
          next_flash = 8'(rbrs_pkg::FLASH_MS);
        end else if (!pressed) begin
          next_state = rbrs_pkg::ST_IDLE;
        end else if (ms_tick) begin
          // R03 burst timing
          next_ms_cnt = ms_cnt + 7'h01;
          if (state == rbrs_pkg::ST_ON && ms_cnt == 7'(rbrs_pkg::BURST_ON_MS - 1)) begin
            next_state = rbrs_pkg::ST_OFF;
            next_ms_cnt = 7'h00;
          end else if (state == rbrs_pkg::ST_OFF && ms_cnt == 7'(rbrs_pkg::BURST_OFF_MS - 1)) begin
            next_state = rbrs_pkg::ST_ON;
            next_ms_cnt = 7'h00;
          end
        end
      end
      // R13 serial record
      rbrs_pkg::ST_SEND: begin
        if (fifo_ready) begin
          push = 1'b1;
          push_data = idx < len ? byte_of(rec, idx) : (idx == len ? rbrs_pkg::CH_CR : rbrs_pkg::CH_LF);
          next_idx = idx + 3'h1;
          if (last) next_state = store ? rbrs_pkg::ST_STORE : rbrs_pkg::ST_IDLE;
        end
      end
      // R14 log the code
      rbrs_pkg::ST_STORE: begin
        next_nvm_req = 1'b1;
        next_nvm_we = 1'b1;
        next_nvm_addr = rbrs_pkg::NVM_LOG_BASE + {4'h0, log_ptr};
        next_nvm_wdata = rec;
        if (nvm_req && nvm_ack) begin
          next_nvm_req = 1'b0;
          next_nvm_we = 1'b0;
          next_log_ptr = log_ptr + 4'h1;
          next_state = rbrs_pkg::ST_IDLE;
        end
      end
      rbrs_pkg::ST_ARG: begin
        if (rx_valid) begin
          if (cmd == rbrs_pkg::CH_S) next_cfg = rx_data;
          else next_mode = rx_data[0];
          next_rec = msg(rbrs_pkg::CH_K, 8'h00);
          next_len = 3'h1;
          next_state = rbrs_pkg::ST_SEND;
        end
      end
      default: begin
        // Reads back the newest logged code; empty slots read as memory holds them
        next_nvm_req = 1'b1;
        next_nvm_we = 1'b0;
        next_nvm_addr = rbrs_pkg::NVM_LOG_BASE + {4'h0, log_ptr - 4'h1};
        if (nvm_req && nvm_ack) begin
          next_nvm_req = 1'b0;
          next_rec = nvm_rdata;
          next_len = 3'(rbrs_pkg::ID_BYTES);
          next_state = rbrs_pkg::ST_SEND;
        end
      end
    endcase
    next_car_on = (next_state == rbrs_pkg::ST_ON);
    // R02 divider held in reset
    next_div = car_on ? div + 1'b1 : '0;
    // R01 divide by 128
    next_carrier = car_on && div[rbrs_pkg::DIV_W-1];
    // R07 red follows bursts
    next_red = next_car_on;
    next_green = (next_flash != 8'h00);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= rbrs_pkg::ST_LOAD;
      ms_div <= '0;
      ms_cnt <= 7'h00;
      div <= '0;
      car_on <= 1'b0;
      carrier_out <= 1'b0;
      red_led <= 1'b0;
      green_led <= 1'b0;
      beeper <= 1'b0;
      flash <= 8'h00;
      cfg <= rbrs_pkg::CFG_RESET;
      cmd <= 8'h00;
      mode <= 1'b0;
      store <= 1'b0;
      term <= 1'b0;
      rec <= '0;
      len <= 3'h0;
      idx <= 3'h0;
      log_ptr <= 4'h0;
      nvm_req <= 1'b0;
      nvm_we <= 1'b0;
      nvm_addr <= 8'h00;
      nvm_wdata <= '0;
      hsr <= '0;
      fsr <= '0;
      hcnt <= '0;
      fcnt <= '0;
    end else begin
      state <= next_state;
      ms_div <= next_ms_div;
      ms_cnt <= next_ms_cnt;
      div <= next_div;
      car_on <= next_car_on;
      carrier_out <= next_carrier;
      red_led <= next_red;
      green_led <= next_green;
      beeper <= next_green;
      flash <= next_flash;
      cfg <= next_cfg;
      cmd <= next_cmd;
      mode <= next_mode;
      store <= next_store;
      term <= next_term;
      rec <= next_rec;
      len <= next_len;
      idx <= next_idx;
      log_ptr <= next_log_ptr;
      nvm_req <= next_nvm_req;
      nvm_we <= next_nvm_we;
      nvm_addr <= next_nvm_addr;
      nvm_wdata <= next_nvm_wdata;
      hsr <= next_hsr;
      fsr <= next_fsr;
      hcnt <= next_hcnt;
      fcnt <= next_fcnt;
    end
  end

  // Push stalls in the send state while the FIFO is full
  rbrs_fifo #(.W(8), .DEPTH(rbrs_pkg::FIFO_DEPTH)) u_fifo (
    .clock(clock), .rstn(rstn), .in_valid(push), .in_data(push_data), .in_ready(fifo_ready),
    .out_valid(fifo_valid), .out_ready(tx_ready), .out_data(fifo_data));

  rbrs_uart #(.BAUD_CYCLES(BAUD_CYCLES)) u_uart (
    .clock(clock), .rstn(rstn), .tx_valid(fifo_valid), .tx_data(fifo_data), .tx_ready(tx_ready),
    .txd(uart_txd), .rxd(uart_rxd), .rx_valid(rx_valid), .rx_data(rx_data));

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_div_reset; state != rbrs_pkg::ST_ON |-> ##2 !carrier_out; endproperty
  a_div_reset: assert property (p_div_reset) else $error("carrier runs while off"); // R02
  property p_half; $rose(carrier_out) |-> ##64 ($fell(carrier_out) || !car_on || !$past(car_on)); endproperty
  a_half: assert property (p_half) else $error("carrier half period not 64"); // R01
  property p_on_end;
    state == rbrs_pkg::ST_ON && ms_tick && ms_cnt == 7'd79 && !dec_valid && pressed |=> state == rbrs_pkg::ST_OFF;
  endproperty
  a_on_end: assert property (p_on_end) else $error("on interval not 80 ms"); // R03
  property p_off_end;
    state == rbrs_pkg::ST_OFF && ms_tick && ms_cnt == 7'd29 && !dec_valid && pressed |=> state == rbrs_pkg::ST_ON;
  endproperty
  a_off_end: assert property (p_off_end) else $error("off interval not 30 ms"); // R03
  property p_hdx_win; state != rbrs_pkg::ST_OFF |=> hcnt == '0; endproperty
  a_hdx_win: assert property (p_hdx_win) else $error("hdx decode outside off window"); // R04
  property p_fdx_win; state != rbrs_pkg::ST_ON |=> fcnt == '0; endproperty
  a_fdx_win: assert property (p_fdx_win) else $error("fdx decode outside on window"); // R05
  property p_red; state == rbrs_pkg::ST_ON && $past(state) == rbrs_pkg::ST_ON |-> red_led; endproperty
  a_red: assert property (p_red) else $error("red not lit during burst"); // R07
  property p_read; dec_valid |=> green_led && beeper && state == rbrs_pkg::ST_SEND ##1 !red_led && !carrier_out; endproperty
  a_read: assert property (p_read) else $error("valid read not acted on"); // R08
  property p_cmd_busy; rx_valid && (state == rbrs_pkg::ST_ON || state == rbrs_pkg::ST_OFF ||
    !tx_quiet) && state != rbrs_pkg::ST_ARG
    |=> state != rbrs_pkg::ST_ARG && state != rbrs_pkg::ST_LOG; endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("command taken while busy"); // R15
  property p_store; state == rbrs_pkg::ST_STORE && nvm_req |-> nvm_we && nvm_wdata == rec; endproperty
  a_store: assert property (p_store) else $error("log write malformed"); // R14

  c_burst: cover property (state == rbrs_pkg::ST_OFF ##1 state == rbrs_pkg::ST_ON);
  c_read: cover property (dec_valid ##[1:40] state == rbrs_pkg::ST_STORE);
  c_cmd: cover property (state == rbrs_pkg::ST_IDLE && rx_valid && tx_quiet);
endmodule

// ===== sim/rbrs_nvm_model.sv
// Memory model that answers word requests after a short wait
`timescale 1ns/1ps
module rbrs_nvm_model (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      req,
  input  wire logic                      we,
  input  wire logic [7:0]                addr,
  input  wire logic [rbrs_pkg::ID_W-1:0] wdata,
  output logic [rbrs_pkg::ID_W-1:0]      rdata,
  output logic                           ack
);
  logic [rbrs_pkg::ID_W-1:0] mem [0:255];
  logic [1:0]                wait_cnt;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // Signed config with terminator bit clear
      mem[0] <= 40'h00_0000_A500;
      ack <= 1'b0;
      wait_cnt <= 2'd0;
      rdata <= '1;
    end else if (req && !ack && wait_cnt == 2'd2) begin
      ack <= 1'b1;
      wait_cnt <= 2'd0;
      rdata <= mem[addr];
      if (we) mem[addr] <= wdata;
    end else begin
      ack <= 1'b0;
      wait_cnt <= (req && !ack) ? wait_cnt + 2'd1 : 2'd0;
      // Read data is only good in the ack cycle
      rdata <= ~rdata;
    end
  end
endmodule

// ===== sim/tb_rbrs_top.sv
// Self-checking bench for the burst read sequencer
`timescale 1ns/1ps
module tb_rbrs_top;
  localparam int BC = 16;
  localparam logic [39:0] ID = 40'h12_3456_789A;
  localparam logic [39:0] MENU = 40'h56_4353_4D4C;
  logic        clock, rstn, read_btn_n, hdx_data, hdx_sync, fdx_data, fdx_sync, uart_rxd;
  logic        uart_txd, carrier_out, red_led, green_led, beeper, nvm_req, nvm_we, nvm_ack;
  logic [7:0]  nvm_addr, b;
  logic [39:0] nvm_wdata, nvm_rdata;
  int          miscompares, cmp_count, n;
  rbrs_top #(.MS_CYCLES(100), .BAUD_CYCLES(BC)) i_rbrs_top (.clock(clock), .rstn(rstn),
    .read_btn_n(read_btn_n), .hdx_data(hdx_data), .hdx_sync(hdx_sync), .fdx_data(fdx_data),
    .fdx_sync(fdx_sync), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .carrier_out(carrier_out),
    .red_led(red_led), .green_led(green_led), .beeper(beeper), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack));
  rbrs_nvm_model i_rbrs_nvm_model (.clock(clock), .rstn(rstn), .req(nvm_req), .we(nvm_we),
    .addr(nvm_addr), .wdata(nvm_wdata), .rdata(nvm_rdata), .ack(nvm_ack));
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d of %0d compares", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      cyc(1);
      uart_rxd <= f[i];
      cyc(BC - 1);
    end
  endtask
  // Start bit found, then each bit taken mid-cell
  task automatic rx(input logic [7:0] exp);
    for (n = 0; uart_txd !== 1'b0 && n < 20000; n++) cyc(1);
    cyc(BC / 2);
    for (int i = 0; i < 8; i++) begin
      cyc(BC);
      b[i] = uart_txd;
    end
    cyc(BC);
    check(b, exp);
  endtask
  task automatic tag(input logic fdx, input logic [48:0] f, input int len);
    for (int i = len - 1; i >= 0; i--) begin
      if (fdx) {fdx_data, fdx_sync} <= {f[i], 1'b0};
      else {hdx_data, hdx_sync} <= {f[i], 1'b0};
      cyc(4);
      if (fdx) fdx_sync <= 1'b1;
      else hdx_sync <= 1'b1;
      cyc(4);
    end
  endtask
  task automatic stay(input logic lvl);
    for (n = n; red_led === lvl && n < 9000; n++) cyc(1);
  endtask
  task automatic test_commands();
    cyc(300);
    check({red_led, carrier_out}, 2'b00);
    tx(8'h56);
    rx(8'h56);
    rx(8'h10);
    tx(8'h43);
    rx(8'h43);
    rx(8'h00);
    tx(8'h3F);
    for (int i = 4; i >= 0; i--) rx(MENU[i*8 +: 8]);
    tx(8'h5A);
    rx(8'h45);
    rx(8'h01);
    tx(8'h53);
    tx(8'h01);
    rx(8'h4B);
    tx(8'h4D);
    tx(8'h01);
    rx(8'h4B);
    read_btn_n <= 1'b0;
    cyc(20);
    check(red_led, 1'b0);
    read_btn_n <= 1'b1;
    tx(8'h4D);
    tx(8'h00);
    rx(8'h4B);
  endtask
  task automatic test_bursts();
    read_btn_n <= 1'b0;
    n = 0;
    stay(1'b0);
    n = 0;
    stay(1'b1);
    n = 0;
    // Full-duplex frame while carrier is off must be dropped
    tag(1'b1, {8'h81, ID, ^ID}, 49);
    n = 392;
    check({green_led, carrier_out}, 2'b00);
    stay(1'b0);
    check(n, 3000);
    for (n = 0; carrier_out !== 1'b0 && n < 200; n++) cyc(1);
    for (n = 0; carrier_out !== 1'b1 && n < 200; n++) cyc(1);
    for (n = 0; carrier_out === 1'b1 && n < 200; n++) cyc(1);
    for (n = n; carrier_out !== 1'b1 && n < 200; n++) cyc(1);
    check(n, 128);
    n = 193;
    stay(1'b1);
    check(n, 8000);
  endtask
  task automatic test_read();
    n = 0;
    stay(1'b0);
    // Half-duplex frame while carrier is on must be dropped
    tag(1'b0, {8'h7E, ID}, 48);
    check(green_led, 1'b0);
    tag(1'b1, {8'h81, ID, ^ID}, 49);
    for (n = 0; green_led !== 1'b1 && n < 20; n++) cyc(1);
    cyc(2);
    check({green_led, beeper}, 2'b11);
    check({red_led, carrier_out}, 2'b00);
    for (int i = 4; i >= 0; i--) rx(ID[i*8 +: 8]);
    rx(8'h0D);
    rx(8'h0A);
    cyc(50);
    check(i_rbrs_nvm_model.mem[1], ID);
    cyc(9000);
    check(red_led, 1'b0);
    tx(8'h4C);
    for (int i = 4; i >= 0; i--) rx(ID[i*8 +: 8]);
    read_btn_n <= 1'b1;
    cyc(10);
    read_btn_n <= 1'b0;
    cyc(10);
    check(red_led, 1'b1);
    tx(8'h56);
    for (n = 0; uart_txd === 1'b1 && n < 300; n++) cyc(1);
    check(n, 300);
    n = 0;
    stay(1'b1);
    tag(1'b0, {8'h7E, ID}, 48);
    cyc(3);
    check({green_led, red_led}, 2'b10);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rstn, hdx_data, hdx_sync, fdx_data, fdx_sync} = 5'h00;
    {read_btn_n, uart_rxd, miscompares, cmp_count} = {2'b11, 64'h0};
    cyc(16);
    rstn <= 1'b1;
    test_commands();
    test_bursts();
    test_read();
    give_verdict();
  end
  // Run needs roughly 47000 cycles
  initial begin
    cyc(100000);
    miscompares++;
    give_verdict();
  end
endmodule
